// File: rtw_chk.sv
// Concurrent checks on the two-wire link between both ends.
`timescale 1ns/10ps
`default_nettype none
`include "rtw_defs.svh"

module rtw_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic supply_low,
  input wire logic scl,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic sda
);
  // ==================================================================
  // Wire decoding
  logic scl_q_ff, sda_q_ff, xfer_ff, first_ff, rd_ff, armed_ff;
  logic [3:0] bit_ff;
  logic [7:0] shift_ff;

  // Conditions and bit slots are decoded from the wire alone. A pulse is
  // counted only when it falls after its own rise, so the pulse carrying a
  // START or STOP never counts as a bit; bit_ff holds completed pulses.
  wire logic start_w = scl && scl_q_ff && sda_q_ff && !sda;
  wire logic stop_w = scl && scl_q_ff && !sda_q_ff && sda;
  wire logic rise_w = scl && !scl_q_ff;
  wire logic fall_w = !scl && scl_q_ff && armed_ff;
  wire logic hi_w = scl && scl_q_ff;
  wire logic wrap_w = fall_w && bit_ff == 4'h8;
  wire logic [3:0] nxt_bit = start_w ? 4'h0 :
    !fall_w ? bit_ff : wrap_w ? 4'h0 : bit_ff + 4'h1;
  wire logic nxt_armed = rise_w || (armed_ff && scl && !start_w && !stop_w);
  wire logic nxt_first = start_w || (first_ff && !wrap_w);
  wire logic nxt_rd = (rise_w && first_ff && bit_ff == 4'h7) ? sda : rd_ff;
  wire logic nxt_xfer = start_w || (xfer_ff && !stop_w);
  // The acknowledge bit is kept out so the byte stays whole in slot 9.
  wire logic [7:0] nxt_shift = (rise_w && bit_ff != 4'h8) ?
    {shift_ff[6:0], sda} : shift_ff;

  // Helper state, idle lines after reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      {xfer_ff, first_ff, rd_ff, armed_ff, bit_ff, shift_ff} <= '0;
    end else begin
      scl_q_ff <= scl;
      sda_q_ff <= sda;
      {xfer_ff, first_ff, rd_ff} <= {nxt_xfer, nxt_first, nxt_rd};
      armed_ff <= nxt_armed;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
    end
  end

  // ==================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_open_drain: assert property (
    (d_sda_oe |-> !d_sda_o) and (h_sda_oe |-> !h_sda_o))
    else $error("driver pushes data line high");
  chk_pull_in_low: assert property (
    $rose(d_sda_oe) |-> !scl) else $error("device pulls while clock high");
  chk_data_stable: assert property (
    hi_w && xfer_ff && bit_ff != 4'h0 |-> sda == sda_q_ff)
    else $error("data moved in clock high");
  chk_ack_slot: assert property (
    hi_w && d_sda_oe && (first_ff || !rd_ff) |-> bit_ff == 4'h8)
    else $error("device acknowledge out of slot");
  chk_addr_ack: assert property (
    hi_w && first_ff && bit_ff == 4'h8 && !supply_low |->
      d_sda_oe == (shift_ff[7:1] == `RTW_SLAVE_ADDR))
    else $error("address acknowledge wrong");
  chk_rd_release: assert property (
    hi_w && rd_ff && !first_ff && bit_ff == 4'h8 |-> !d_sda_oe)
    else $error("transmitter holds acknowledge slot");
  chk_whole_bytes: assert property (
    (start_w && xfer_ff) || stop_w |-> bit_ff == 4'h0)
    else $error("condition inside a byte");
  chk_start_first: assert property (
    rise_w |-> xfer_ff) else $error("clock pulse outside transfer");
  chk_idle_quiet: assert property (
    !xfer_ff && !start_w |-> !d_sda_oe && !h_sda_oe && scl)
    else $error("idle bus disturbed");
endmodule

`default_nettype wire

// File: rtw_defs.svh
// Constants shared by both ends of the two-wire bus condition layer.
`ifndef RTW_DEFS_SVH
`define RTW_DEFS_SVH

// =====================================================================
// Timing
`define RTW_CLK_KHZ 50000
`define RTW_CLK_NS 20
`define RTW_SCL_KHZ 100
`define RTW_TLP_MIN_NS 250
`define RTW_TLP_CYC ((`RTW_TLP_MIN_NS + `RTW_CLK_NS - 1) / `RTW_CLK_NS)
`define RTW_FLT_LAST 4'(`RTW_TLP_CYC - 1)
`define RTW_QTR_LAST 7'(`RTW_CLK_KHZ / (`RTW_SCL_KHZ * 4) - 1)

// =====================================================================
// Framing
`define RTW_SLAVE_ADDR 7'h68
`define RTW_BYTE_BITS 4'h8
`define RTW_IDLE_BYTE 8'hFF
`define RTW_DATA_W 8
`define RTW_FIFO_DEPTH 16

`endif

// File: rtw_dev_end.sv
// Device end: bus condition detection and byte framing of the slave.
`timescale 1ns/10ps
`default_nettype none
`include "rtw_defs.svh"

module rtw_dev_end
  import rtw_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic supply_low,
  rtw_if.dev link,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_taken,
  output logic selected,
  output logic reading,
  output logic addr_clear
);
  // ===================================================================
  // Input synchronisers and spike filters
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic filt_ff [2];
  logic [3:0] flt_cnt_ff [2];
  logic scl_q_ff;
  logic sda_q_ff;
  logic pwr_q_ff;

  // Bit 0 clock, bit 1 data, bit 2 supply-low comparator.
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_ff <= 3'h3;
      sync_ff <= 3'h3;
    end else if (ce) begin
      meta_ff <= {supply_low, link.sda, link.scl};
      sync_ff <= meta_ff;
    end
  end

  // A line level is taken only after it stood for the filter time, so
  // spikes shorter than that never reach the edge detectors.
  for (genvar i = 0; i < 2; i++) begin : g_flt
    always_ff @(posedge clock) begin
      if (reset) begin
        filt_ff[i] <= 1'b1;
        flt_cnt_ff[i] <= 4'h0;
      end else if (ce) begin
        if (sync_ff[i] == filt_ff[i]) begin
          flt_cnt_ff[i] <= 4'h0;
        end else if (flt_cnt_ff[i] == `RTW_FLT_LAST) begin
          filt_ff[i] <= sync_ff[i];
          flt_cnt_ff[i] <= 4'h0;
        end else begin
          flt_cnt_ff[i] <= flt_cnt_ff[i] + 4'h1;
        end
      end
    end
  end

  // ===================================================================
  // Bus conditions
  wire logic scl_f = filt_ff[0];
  wire logic sda_f = filt_ff[1];
  wire logic pwr_dn = sync_ff[2];
  // Edges are seen at any clock rate slow enough to pass the filters, since nothing is timed here.
  wire logic scl_rise = scl_f & ~scl_q_ff;
  wire logic scl_fall = ~scl_f & scl_q_ff;
  // Idle bus is both lines high; a START can only leave that state.
  wire logic bus_idle = scl_q_ff & sda_q_ff;
  // A data change with clock high is a condition, never a bit.
  wire logic hi_hold = scl_f & scl_q_ff;
  wire logic start_det = bus_idle & scl_f & ~sda_f;
  wire logic stop_det = hi_hold & ~sda_q_ff & sda_f;

  // Previous filtered line levels and previous synchronised supply-low level.
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      pwr_q_ff <= 1'b0;
    end else if (ce) begin
      scl_q_ff <= scl_f;
      sda_q_ff <= sda_f;
      pwr_q_ff <= pwr_dn;
    end
  end

  // ===================================================================
  // Byte framing
  rtw_dstate_e state_ff;
  rtw_dstate_e nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic oe_ff;
  logic nxt_oe;
  logic rw_ff;
  logic nxt_rw;
  logic mack_ff;
  logic nxt_mack;
  logic push;
  logic take;
  logic fifo_in_ready;
  logic taken_ff;
  logic sel_ff;
  logic clr_ff;
  logic read_ff;

  wire logic byte_done = scl_fall & (cnt_ff == `RTW_BYTE_BITS);
  wire logic addr_hit = (sh_ff[7:1] == `RTW_SLAVE_ADDR);
  wire logic [7:0] ld_byte = tx_valid ? tx_data : `RTW_IDLE_BYTE;
  wire logic [3:0] cnt_inc = cnt_ff + 4'h1;
  wire logic nxt_sel = (nxt_state != RTW_D_IDLE) && (nxt_state != RTW_D_ADDR);

  // Next-state decode; conditions take priority over bit handling.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_oe = oe_ff;
    nxt_rw = rw_ff;
    nxt_mack = mack_ff;
    push = 1'b0;
    take = 1'b0;
    if (pwr_dn) begin
      // Below switch-over the pin is released and inputs are ignored.
      nxt_state = RTW_D_IDLE;
      nxt_oe = 1'b0;
    end else if (stop_det) begin
      nxt_state = RTW_D_IDLE;
      nxt_oe = 1'b0;
    end else if (start_det) begin
      // A START in mid transfer restarts address reception.
      nxt_state = RTW_D_ADDR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else begin
      unique case (state_ff)
        RTW_D_IDLE: begin
          nxt_oe = 1'b0;
        end
        RTW_D_ADDR, RTW_D_WRX: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_f};
            nxt_cnt = cnt_inc;
          end
          if (byte_done && state_ff == RTW_D_ADDR) begin
            // Only our own address is answered; R/W sits in bit 0.
            nxt_state = addr_hit ? RTW_D_AACK : RTW_D_IDLE;
            nxt_oe = addr_hit;
            nxt_rw = sh_ff[0];
          end else if (byte_done) begin
            // No byte limit; a full FIFO withholds the acknowledge.
            push = 1'b1;
            nxt_oe = fifo_in_ready;
            nxt_state = RTW_D_WACK;
          end
        end
        RTW_D_AACK, RTW_D_WACK: begin
          if (scl_fall && state_ff == RTW_D_AACK && rw_ff) begin
            take = tx_valid;
            nxt_sh = ld_byte;
            nxt_oe = ~ld_byte[7];
            nxt_cnt = 4'h0;
            nxt_state = RTW_D_RTX;
          end else if (scl_fall) begin
            nxt_oe = 1'b0;
            nxt_cnt = 4'h0;
            nxt_state = RTW_D_WRX;
          end
        end
        RTW_D_RTX: begin
          if (scl_rise) begin
            nxt_cnt = cnt_inc;
          end
          if (byte_done) begin
            nxt_oe = 1'b0;
            nxt_state = RTW_D_RACK;
          end else if (scl_fall) begin
            // Data moves only after the clock has fallen.
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_oe = ~sh_ff[6];
          end
        end
        RTW_D_RACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_f;
          end
          if (scl_fall && mack_ff) begin
            take = tx_valid;
            nxt_sh = ld_byte;
            nxt_oe = ~ld_byte[7];
            nxt_cnt = 4'h0;
            nxt_state = RTW_D_RTX;
          end else if (scl_fall) begin
            // Master ended the read: leave the line high for its STOP.
            nxt_oe = 1'b0;
            nxt_state = RTW_D_IDLE;
          end
        end
        default: begin
          nxt_state = RTW_D_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Framing registers and registered status outputs.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= RTW_D_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      taken_ff <= 1'b0;
      sel_ff <= 1'b0;
      clr_ff <= 1'b0;
      read_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      oe_ff <= nxt_oe;
      rw_ff <= nxt_rw;
      mack_ff <= nxt_mack;
      taken_ff <= take;
      sel_ff <= nxt_sel;
      read_ff <= nxt_sel & nxt_rw;
      clr_ff <= pwr_dn & ~pwr_q_ff;
    end
  end

  // ===================================================================
  // Receive buffer and outputs
  rtw_fifo #(
    .W(`RTW_DATA_W),
    .D(`RTW_FIFO_DEPTH)
  ) u_rx_fifo (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(sh_ff),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // Pin value is a constant low: the pad only ever pulls down.
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe = oe_ff;
  assign tx_taken = taken_ff;
  assign selected = sel_ff;
  assign reading = read_ff;
  assign addr_clear = clr_ff;
endmodule

`default_nettype wire

// File: rtw_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
`include "rtw_defs.svh"

module rtw_fifo #(
  parameter int W = `RTW_DATA_W,
  parameter int D = `RTW_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic full_ff;
  logic empty_ff;
  logic [AW:0] nxt_cnt;
  wire logic do_wr = in_valid & ~full_ff;
  wire logic do_rd = out_ready & ~empty_ff;

  // Full and empty are registered so both handshakes leave a flop.
  assign in_ready = ~full_ff;
  assign out_valid = ~empty_ff;
  assign out_data = mem_ff[rd_ff];
  assign nxt_cnt = cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};

  // Pointers and occupancy.
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
    end else if (ce) begin
      wr_ff <= wr_ff + AW'(do_wr);
      rd_ff <= rd_ff + AW'(do_rd);
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == (AW+1)'(D));
      empty_ff <= (nxt_cnt == '0);
    end
  end

  // Storage needs no reset; only written words are ever read.
  always_ff @(posedge clock) begin
    if (ce && do_wr) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

`default_nettype wire

// File: rtw_host_end.sv
// Master end: clock divider and START, STOP and byte sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "rtw_defs.svh"

module rtw_host_end
  import rtw_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  rtw_if.host link,
  input wire logic cmd_valid,
  input wire rtw_op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic bus_busy
);
  // ===================================================================
  // Registers
  logic sda_m_ff;
  logic sda_s_ff;
  logic [6:0] div_ff;
  logic [1:0] ph_ff;
  rtw_hstate_e state_ff;
  rtw_hstate_e nxt_state;
  logic [8:0] sh_ff;
  logic [8:0] nxt_sh;
  logic [8:0] rx_ff;
  logic [8:0] nxt_rx;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic scl_ff;
  logic nxt_scl;
  logic oe_ff;
  logic nxt_oe;
  logic busy_ff;
  logic nxt_busy;
  logic rdy_ff;
  logic rv_ff;
  logic nxt_rv;

  wire logic tick = (div_ff == `RTW_QTR_LAST);
  wire logic accept = cmd_valid & rdy_ff & (state_ff == RTW_H_WAIT);
  // A fresh transfer waits for both lines high in the coming cycle.
  wire logic bus_free = sda_s_ff & nxt_scl;

  // Line sampler; the bit sample is taken late in the high quarter.
  always_ff @(posedge clock) begin
    if (reset) begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      div_ff <= 7'h00;
    end else if (ce) begin
      sda_m_ff <= link.sda;
      sda_s_ff <= sda_m_ff;
      div_ff <= (tick || state_ff == RTW_H_WAIT) ? 7'h00 : div_ff + 7'h01;
    end
  end

  // ===================================================================
  // Sequencer: each step is four quarters of the bit period.
  always_comb begin
    nxt_state = state_ff;
    nxt_sh = sh_ff;
    nxt_rx = rx_ff;
    nxt_cnt = cnt_ff;
    nxt_scl = scl_ff;
    nxt_oe = oe_ff;
    nxt_busy = busy_ff;
    nxt_rv = 1'b0;
    unique case (state_ff)
      RTW_H_WAIT: begin
        if (accept) begin
          nxt_cnt = 4'h0;
          unique case (cmd_op)
            RTW_OP_START: nxt_state = RTW_H_START;
            RTW_OP_WRITE: begin
              nxt_sh = {cmd_data, 1'b1};
              nxt_state = busy_ff ? RTW_H_BITS : RTW_H_WAIT;
            end
            RTW_OP_READ: begin
              // Acknowledge every read byte except the last one.
              nxt_sh = {`RTW_IDLE_BYTE, cmd_last};
              nxt_state = busy_ff ? RTW_H_BITS : RTW_H_WAIT;
            end
            RTW_OP_STOP: nxt_state = busy_ff ? RTW_H_STOP : RTW_H_WAIT;
          endcase
          // A byte or STOP outside a transfer is dropped with a NACK.
          nxt_rv = ~busy_ff & (cmd_op != RTW_OP_START);
          nxt_rx = 9'h1FF;
        end
      end
      RTW_H_START: begin
        if (tick) begin
          unique case (ph_ff)
            2'h0: nxt_oe = 1'b0;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b1;
            2'h3: begin
              nxt_scl = 1'b0;
              nxt_busy = 1'b1;
              nxt_state = RTW_H_WAIT;
            end
          endcase
        end
      end
      RTW_H_BITS: begin
        if (tick) begin
          unique case (ph_ff)
            // Data moves only in the low quarter.
            2'h0: nxt_oe = ~sh_ff[8];
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_rx = {rx_ff[7:0], sda_s_ff};
            2'h3: begin
              nxt_scl = 1'b0;
              nxt_sh = {sh_ff[7:0], 1'b1};
              nxt_cnt = cnt_ff + 4'h1;
              if (cnt_ff == `RTW_BYTE_BITS) begin
                nxt_rv = 1'b1;
                nxt_state = RTW_H_WAIT;
              end
            end
          endcase
        end
      end
      RTW_H_STOP: begin
        if (tick) begin
          unique case (ph_ff)
            2'h0: nxt_oe = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe = 1'b0;
            2'h3: begin
              nxt_busy = 1'b0;
              nxt_state = RTW_H_WAIT;
            end
          endcase
        end
      end
    endcase
  end

  // Sequencer registers; the clock line idles high after reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= RTW_H_WAIT;
      ph_ff <= 2'h0;
      sh_ff <= 9'h1FF;
      rx_ff <= 9'h1FF;
      cnt_ff <= 4'h0;
      scl_ff <= 1'b1;
      oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      rdy_ff <= 1'b0;
      rv_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      ph_ff <= (state_ff == RTW_H_WAIT) ? 2'h0 : ph_ff + 2'(tick);
      sh_ff <= nxt_sh;
      rx_ff <= nxt_rx;
      cnt_ff <= nxt_cnt;
      scl_ff <= nxt_scl;
      oe_ff <= nxt_oe;
      busy_ff <= nxt_busy;
      rdy_ff <= (nxt_state == RTW_H_WAIT) && !accept && !nxt_rv &&
        (nxt_busy || bus_free);
      rv_ff <= nxt_rv;
    end
  end

  // Outputs; the data pin is open drain like the device's.
  assign link.scl = scl_ff;
  assign link.h_sda_o = 1'b0;
  assign link.h_sda_oe = oe_ff;
  assign cmd_ready = rdy_ff;
  assign rsp_valid = rv_ff;
  assign rsp_data = rx_ff[8:1];
  assign rsp_nack = rx_ff[0];
  assign bus_busy = busy_ff;
endmodule

`default_nettype wire

// File: rtw_if.sv
// Two-wire link between master end and device end.
`timescale 1ns/10ps
`default_nettype none

interface rtw_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  wire logic sda;

  // Wired-AND with pull-up: any enabled driver at low pulls the line low.
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

  modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
  modport dev (input scl, output d_sda_o, output d_sda_oe, input sda);
endinterface

`default_nettype wire

// File: rtw_pkg.sv
// Types shared by both ends of the two-wire bus condition layer.
`default_nettype none

package rtw_pkg;

  // Device framing states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    RTW_D_IDLE = 3'h0,
    RTW_D_ADDR = 3'h1,
    RTW_D_AACK = 3'h3,
    RTW_D_WRX = 3'h2,
    RTW_D_WACK = 3'h6,
    RTW_D_RTX = 3'h7,
    RTW_D_RACK = 3'h5
  } rtw_dstate_e;

  // Master sequencer states.
  typedef enum logic [1:0] {
    RTW_H_WAIT = 2'h0,
    RTW_H_START = 2'h1,
    RTW_H_BITS = 2'h3,
    RTW_H_STOP = 2'h2
  } rtw_hstate_e;

  // Commands accepted by the master end.
  typedef enum logic [1:0] {
    RTW_OP_START = 2'h0,
    RTW_OP_WRITE = 2'h1,
    RTW_OP_READ = 2'h2,
    RTW_OP_STOP = 2'h3
  } rtw_op_e;

endpackage

`default_nettype wire

// File: rtw_two_wire_bus_conditions_tb.sv
// Testbench joining the master end and the device end over the link.
`timescale 1ns/10ps
`default_nettype none
`include "rtw_defs.svh"

module rtc_two_wire_bus_conditions_tb import rtw_pkg::*;;
  // ==================================================================
  // Stimulus and model state
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic supply_low = 1'b0;
  logic rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h20;
  logic cmd_valid = 1'b0;
  rtw_op_e cmd_op = RTW_OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  logic rx_valid, tx_taken, selected, reading, addr_clear;
  logic cmd_ready, rsp_valid, rsp_nack, bus_busy;
  logic [7:0] rx_data, rsp_data, seed;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int errors = 0;
  int total_checks = 0;
  int n;
  rtw_if lk();

  always #10 clock = ~clock;

  rtw_host_end i_rtw_host_end (.clock(clock), .reset(reset), .ce(1'b1),
    .link(lk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus_busy(bus_busy));
  rtw_dev_end i_rtw_dev_end (.clock(clock), .reset(reset), .ce(1'b1),
    .supply_low(supply_low), .link(lk), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(1'b1),
    .tx_data(tx_data), .tx_taken(tx_taken), .selected(selected),
    .reading(reading), .addr_clear(addr_clear));
  rtw_chk i_rtw_chk (.clock(clock), .reset(reset), .supply_low(supply_low),
    .scl(lk.scl), .h_sda_o(lk.h_sda_o), .h_sda_oe(lk.h_sda_oe),
    .d_sda_o(lk.d_sda_o), .d_sda_oe(lk.d_sda_oe), .sda(lk.sda));

  // ==================================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic limit(input int cnt, input int max);
    if (cnt >= max) begin
      chk(1'b0, "wait ran out");
      tally_and_finish();
    end
  endtask

  // The model queues each byte offered to the device when it is taken.
  always @(posedge clock) begin
    if (tx_taken === 1'b1) begin
      txq.push_back(tx_data);
      tx_data <= lfsr(tx_data);
    end
  end

  // One master command; the request holds until cmd_ready is sampled.
  task automatic op(input rtw_op_e o, input logic [7:0] d, input logic l,
                    input logic enk, input logic ck);
    int k;
    logic [7:0] ed;
    k = 0;
    cmd_op <= o;
    cmd_data <= d;
    cmd_last <= l;
    cmd_valid <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (cmd_ready !== 1'b1 && k < 3000);
    limit(k, 3000);
    cmd_valid <= 1'b0;
    k = 0;
    if (o == RTW_OP_START || o == RTW_OP_STOP) begin
      @(posedge clock);
    end else begin
      do begin
        @(posedge clock);
        k++;
      end while (rsp_valid !== 1'b1 && k < 6000);
      limit(k, 6000);
      ed = (o == RTW_OP_READ) ? txq.pop_front() : d;
      chk(rsp_nack === enk, "acknowledge bit");
      if (ck) chk(rsp_data === ed, "byte value");
    end
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    seed = 8'h20;
    op(RTW_OP_WRITE, 8'h00, 1'b0, 1'b1, 1'b0);
    op(RTW_OP_START, 8'h00, 1'b0, 1'b0, 1'b0);
    op(RTW_OP_WRITE, {`RTW_SLAVE_ADDR, 1'b0}, 1'b0, 1'b0, 1'b1);
    chk(selected === 1'b1 && reading === 1'b0, "write select");
    // The far side stalls so the buffer fills and refuses one byte.
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      if (i < 16) rxq.push_back(seed);
      op(RTW_OP_WRITE, seed, 1'b0, i == 16, 1'b1);
    end
    op(RTW_OP_START, 8'h00, 1'b0, 1'b0, 1'b0);
    op(RTW_OP_WRITE, {`RTW_SLAVE_ADDR, 1'b1}, 1'b0, 1'b0, 1'b1);
    chk(reading === 1'b1, "read select");
    op(RTW_OP_READ, 8'hFF, 1'b0, 1'b0, 1'b1);
    op(RTW_OP_READ, 8'hFF, 1'b1, 1'b1, 1'b1);
    op(RTW_OP_STOP, 8'h00, 1'b0, 1'b0, 1'b0);
    repeat (600) @(posedge clock);
    chk(selected === 1'b0, "held after stop");
    rx_ready <= 1'b1;
    repeat (40) begin
      @(posedge clock);
      if (rx_valid === 1'b1) begin
        chk(rx_data === rxq.pop_front(), "rx byte");
      end
    end
    chk(rxq.size() == 0 && rx_valid === 1'b0, "drain count");
    op(RTW_OP_START, 8'h00, 1'b0, 1'b0, 1'b0);
    op(RTW_OP_WRITE, 8'hA0, 1'b0, 1'b1, 1'b1);
    chk(selected === 1'b0, "foreign address");
    op(RTW_OP_STOP, 8'h00, 1'b0, 1'b0, 1'b0);
    // Supply loss must clear the pointer and make the device deaf.
    supply_low <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (addr_clear !== 1'b1 && n < 10);
    chk(n < 10, "no address clear");
    if (n >= 10) tally_and_finish();
    op(RTW_OP_START, 8'h00, 1'b0, 1'b0, 1'b0);
    op(RTW_OP_WRITE, {`RTW_SLAVE_ADDR, 1'b0}, 1'b0, 1'b1, 1'b1);
    chk(selected === 1'b0, "selected on battery");
    op(RTW_OP_STOP, 8'h00, 1'b0, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
